// [src/pwm_regs.svh]
/*
  Register offsets, field positions, reset values and timing counts of the
  pulse-width modulator.
  Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
*/
// Contract
// - Disabled: output flop held reset, pin equals polarity level.
// - Enabled: polarity zero gives high pulses; polarity one inverts edges.
// - Disabled: divide-by-256 prescaler held in reset, no counter clock.
// - Disabled: counter stopped at 0x0001, comparators inactive.
// - Disabled: write registers copied continuously into both buffers.
// - Enable rising edge sets output flop and releases prescaler.
// - Enable rising edge lets counter count up from 0x0001.
// - Enable rising edge sets status flag: new values may be written.
// - Enabled: output from buffers; buffers refreshed at each period end.
// - Three-bit rate field picks one of eight prescaler taps.
// - Rate field may change at any time during operation.
// - Divide-by-2 base: 2..128, 512; divide-by-3 base: 3..192, 768.
// - Enabled: new period loads at period end or on load bit write.
// - Disabled: new period reaches the buffer on the next clock.
// - Period write register never altered; period buffer not accessible.
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PWM_OFS_CTRL   4'h0
`define PWM_OFS_PERIOD 4'h4
`define PWM_OFS_WIDTH  4'h8
`define PWM_OFS_COUNT  4'hC

// ----------------------------------------------------------------------
// Control and status field positions
// ----------------------------------------------------------------------
`define PWM_BIT_EN     0
`define PWM_BIT_POL    1
`define PWM_BIT_DIV3   2
`define PWM_BIT_LOAD   3
`define PWM_BIT_RATE   4
`define PWM_BIT_FLAG   8
`define PWM_BIT_PIN    9

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define PWM_CNT_START  16'h0001
`define PWM_PRESC_LEN  8

`endif

// [src/pwm_pkg.sv]
/*
  Types of the pulse-width modulator.
  Assumes the constants header is included by the design file.
*/
package pwm_pkg;

  typedef struct packed {
    logic        en;
    logic        en_d;
    logic        output_polarity;
    logic        div3;
    logic [2:0]  rate;
    logic        flag;
    logic        out_ff;
    logic        pin;
    logic [15:0] period_w;
    logic [15:0] width_w;
    logic [15:0] period_buf;
    logic [15:0] width_buf;
    logic [15:0] count;
    logic [7:0]  presc;
    logic [1:0]  base_cnt;
    logic        base_tick_d;
    logic        tap_d;
    logic        awvalid_seen;
    logic        wvalid_seen;
    logic [3:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pwm_state_t;

endpackage : pwm_pkg

// [src/pwm_top.sv]
/*
  Pulse-width modulator with an AXI4-Lite register slave.
  Assumes one clock, an asynchronous active-low reset, and a master that
  keeps at most one write and one read outstanding.
*/
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pwm_regs.svh"

module pwm_top
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             pwm_pin
);

  pwm_pkg::pwm_state_t st;
  pwm_pkg::pwm_state_t next_st;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  be);
    logic [15:0] r;
    r = old;
    if (be[0])
    begin
      r[7:0] = d[7:0];
    end
    if (be[1])
    begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge16

  // Tap of the prescaler chain that clocks the counter for a rate code.
  function automatic logic tap(input logic [7:0] p,
                               input logic [2:0] code);
    logic r;
    unique case (code)
      3'h0: r = 1'b1;
      3'h1: r = p[0];
      3'h2: r = p[1];
      3'h3: r = p[2];
      3'h4: r = p[3];
      3'h5: r = p[4];
      3'h6: r = p[5];
      3'h7: r = p[7];
    endcase
    return r;
  endfunction : tap

  logic        base_tick;
  logic        cnt_tick;
  logic        period_end;
  logic        en_rise;
  logic        wr_go;
  logic [31:0] status_word;

  always_comb
  begin
    // The base divider gives one tick every 2 or 3 system clocks.
    base_tick = st.en && (st.div3 ? (st.base_cnt == 2'h2)
                                  : (st.base_cnt == 2'h1));
    // A counter clock is one base tick at the selected tap's rising edge, or every base tick for rate code 0.
    // Taking the tap's edge rather than its level lets the rate change at
    // any moment without a runaway burst of counts.
    cnt_tick  = base_tick && ((st.rate == 3'h0) ||
                (tap(st.presc, st.rate) && !st.tap_d));
    period_end = st.en && cnt_tick && (st.count >= st.period_buf);
    en_rise    = st.en && !st.en_d;
    wr_go = (st.awvalid_seen || s_axi_awvalid) &&
            (st.wvalid_seen  || s_axi_wvalid) && !st.bvalid;
    status_word = 32'h0000_0000;
    status_word[`PWM_BIT_EN]          = st.en;
    status_word[`PWM_BIT_POL]         = st.output_polarity;
    status_word[`PWM_BIT_DIV3]        = st.div3;
    status_word[`PWM_BIT_RATE +: 3]   = st.rate;
    status_word[`PWM_BIT_FLAG]        = st.flag;
    status_word[`PWM_BIT_PIN]         = st.pin;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [3:0]  a;
    logic [31:0] d;
    logic [3:0]  be;
    logic        load_now;
    next_st  = st;
    a        = st.awvalid_seen ? st.waddr : s_axi_awaddr;
    d        = st.wvalid_seen ? st.wdata : s_axi_wdata;
    be       = st.wvalid_seen ? st.wstrb : s_axi_wstrb;
    load_now = 1'b0;
    next_st.en_d    = st.en;
    next_st.awready = 1'b0;
    next_st.wready  = 1'b0;
    next_st.arready = 1'b0;

    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && !st.awvalid_seen && !st.bvalid)
    begin
      next_st.awvalid_seen = 1'b1;
      next_st.waddr        = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.wvalid_seen && !st.bvalid)
    begin
      next_st.wvalid_seen = 1'b1;
      next_st.wdata       = s_axi_wdata;
      next_st.wstrb       = s_axi_wstrb;
    end
    next_st.awready = s_axi_awvalid && !st.awvalid_seen && !st.bvalid &&
                      !st.awready;
    next_st.wready  = s_axi_wvalid && !st.wvalid_seen && !st.bvalid &&
                      !st.wready;
    if (st.bvalid && s_axi_bready)
    begin
      next_st.bvalid = 1'b0;
    end

    // Prescaler and counter, held while disabled.
    if (!st.en)
    begin
      next_st.presc      = 8'h00;
      next_st.base_cnt   = 2'h0;
      next_st.tap_d      = 1'b0;
      next_st.count      = `PWM_CNT_START;
      next_st.out_ff     = 1'b0;
      next_st.period_buf = st.period_w;
      next_st.width_buf  = st.width_w;
    end
    else
    begin
      next_st.base_cnt = base_tick ? 2'h0 : st.base_cnt + 2'h1;
      if (base_tick)
      begin
        next_st.presc = st.presc + 8'h01;
        next_st.tap_d = tap(st.presc, st.rate);
      end
      if (en_rise)
      begin
        next_st.out_ff = 1'b1;
        next_st.flag   = 1'b1;
      end
      if (period_end)
      begin
        next_st.count      = `PWM_CNT_START;
        // A zero width keeps the pin idle for the whole next period, so
        // software can park the pin before it clears the enable bit.
        next_st.out_ff     = (st.width_w != 16'h0000);
        next_st.flag       = 1'b1;
        next_st.period_buf = st.period_w;
        next_st.width_buf  = st.width_w;
      end
      else if (cnt_tick)
      begin
        next_st.count = st.count + 16'h0001;
        if (st.count >= st.width_buf)
        begin
          next_st.out_ff = 1'b0;
        end
      end
    end

    // Register writes; the period write register is never touched by
    // the modulator itself, and the buffer has no address.
    if (wr_go)
    begin
      next_st.awvalid_seen = 1'b0;
      next_st.wvalid_seen  = 1'b0;
      next_st.bvalid       = 1'b1;
      next_st.bresp        = 2'b00;
      unique case (a)
        `PWM_OFS_CTRL:
        begin
          if (be[0])
          begin
            next_st.en   = d[`PWM_BIT_EN];
            next_st.output_polarity  = d[`PWM_BIT_POL];
            next_st.div3 = d[`PWM_BIT_DIV3];
            load_now     = d[`PWM_BIT_LOAD];
            next_st.rate[0] = d[`PWM_BIT_RATE];
            next_st.rate[1] = d[`PWM_BIT_RATE + 1];
            next_st.rate[2] = d[`PWM_BIT_RATE + 2];
          end
          // Writing zero clears the flag; a set in the same cycle wins.
          if (be[1] && !d[`PWM_BIT_FLAG] && !period_end && !en_rise)
          begin
            next_st.flag = 1'b0;
          end
        end
        `PWM_OFS_PERIOD:
          next_st.period_w = merge16(st.period_w, d, be);
        `PWM_OFS_WIDTH:
          next_st.width_w = merge16(st.width_w, d, be);
        `PWM_OFS_COUNT:
          next_st.bresp = 2'b00;
        default:
          next_st.bresp = 2'b10;
      endcase
      if (load_now && st.en)
      begin
        next_st.period_buf = st.period_w;
      end
    end

    // Read channel.
    if (s_axi_arvalid && !st.rvalid && !st.arready)
    begin
      next_st.arready = 1'b1;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = 2'b00;
      unique case (s_axi_araddr)
        `PWM_OFS_CTRL:   next_st.rdata = status_word;
        `PWM_OFS_PERIOD: next_st.rdata = {16'h0000, st.period_w};
        `PWM_OFS_WIDTH:  next_st.rdata = {16'h0000, st.width_w};
        `PWM_OFS_COUNT:  next_st.rdata = {16'h0000, st.count};
        default:
        begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = 2'b10;
        end
      endcase
    end
    else if (st.rvalid && s_axi_rready)
    begin
      next_st.rvalid = 1'b0;
    end

    // Pin level: polarity zero gives high pulses, one gives low pulses.
    next_st.pin = next_st.out_ff ^ next_st.output_polarity;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;
  assign pwm_pin       = st.pin;

endmodule : pwm_top

// [test/pwm_monitor.sv]
/*
  Concurrent checks of the modulator's bus handshakes and pin.
  Assumes binding to pwm_top; sees only its ports.
*/
`timescale 1ns/1ps

module pwm_monitor
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pwm_pin
);
  // ------------------------------------------------------------------
  // Shadow of enable and polarity, then properties
  // ------------------------------------------------------------------
  logic sh_en;
  logic sh_pol;
  logic ctrl_hs;

  // The design acts on a control write one edge before the handshake that
  // updates the shadow, so the pin is not judged in that cycle.
  assign ctrl_hs = s_axi_awvalid && s_axi_awready && s_axi_awaddr == 4'h0;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {sh_pol, sh_en} <= 2'h0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
             s_axi_wready && s_axi_awaddr == 4'h0 && s_axi_wstrb[0])
      {sh_pol, sh_en} <= s_axi_wdata[1:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence wr_req;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  endsequence
  sequence wr_ack;
    s_axi_awready && s_axi_wready ##[0:1] s_axi_bvalid;
  endsequence

  wr_answer_a: assert property (wr_req |=> wr_ack)
    else $error("write not answered");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  ready_pulse_a: assert property (s_axi_awready || s_axi_arready
    |=> !s_axi_awready && !s_axi_arready)
    else $error("ready longer than one cycle");
  pin_idle_a: assert property (
    !sh_en && !$past(sh_en) && $stable(sh_pol) && !ctrl_hs
    |-> pwm_pin == sh_pol)
    else $error("idle pin not at polarity level");
  pin_start_a: assert property (
    $rose(sh_en) |-> ##[0:2] pwm_pin != sh_pol)
    else $error("first pulse not started");
  pin_steady_a: assert property (
    sh_en && $past(sh_en, 4) && $changed(pwm_pin) |=> $stable(pwm_pin))
    else $error("pin toggled faster than counter clock");
endmodule : pwm_monitor

bind pwm_top pwm_monitor mon_u (.clk, .rst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .pwm_pin);

// [test/tb_pulse_width_modulator.sv]
/*
  Self-checking bench of the modulator: bus master tasks, sweep of all rate
  and divide-by-3 codes with random period and polarity. Assumes pwm_top and its bound monitor.
*/
`timescale 1ns/1ps
`include "pwm_regs.svh"

`define CHK(nm, e, a) \
  begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); end end

module tb_pulse_width_modulator;
  logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_pin, output_polarity;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, c, pa, pb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, wresp;
  int          n_mismatch, total_checks, seed, k, n, cyc, t_rise;

  pwm_top dut_u (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwm_pin);

  // ------------------------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic fail_wait;
    n_mismatch++;
    give_verdict();
  endtask : fail_wait

  // Response ready is offered with the request; one edge passes after each
  // transfer so that no strobe is driven twice in one time step.
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    int i;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      i++;
    end
    while (!s_axi_bvalid && i < 50);
    wresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
    if (i >= 50) fail_wait();
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v,
                    output logic [1:0] e);
    int i;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      i++;
    end
    while (!s_axi_rvalid && i < 50);
    v = s_axi_rdata;
    e = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
    if (i >= 50) fail_wait();
  endtask : rd

  task automatic edge_to(input logic v, output int m);
    m = 0;
    while (pwm_pin !== v && m < 20000)
    begin
      @(posedge clk);
      m++;
    end
    if (m >= 20000) fail_wait();
  endtask : edge_to

  // Clocks from the last seen pulse start to the next one, so that bus
  // traffic in between does not shorten the measurement.
  task automatic period(output int m);
    int a;
    int b;
    edge_to(output_polarity, a);
    edge_to(!output_polarity, b);
    m = cyc - t_rise;
    t_rise = cyc;
  endtask : period

  function automatic int div_of(input logic d3, input logic [2:0] rt);
    return (d3 ? 3 : 2) * (rt == 3'h7 ? 256 : (1 << rt));
  endfunction : div_of

  // ------------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  initial
  begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    seed = 14742;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`PWM_OFS_CTRL, d, r);
    `CHK("ctrl reset", 32'h0, d)
    `CHK("pin reset", 1'b0, pwm_pin)
    rd(4'h2, d, r);
    `CHK("unmapped resp", 2'h2, r)
    for (k = 0; k < 16; k++)
    begin
      output_polarity = 1'($random(seed));
      pa = 32'(8 + ($random(seed) & 3));
      pb = 32'(3 + ($random(seed) & 7));
      c = {25'h0, k[2:0], 1'b0, k[3], output_polarity, 1'b0};
      wr(`PWM_OFS_WIDTH, 32'h2);
      `CHK("write resp", 2'h0, wresp)
      wr(`PWM_OFS_PERIOD, pa);
      wr(`PWM_OFS_CTRL, c);
      repeat (3) @(posedge clk);
      `CHK("idle pin", output_polarity, pwm_pin)
      rd(`PWM_OFS_COUNT, d, r);
      `CHK("idle count", 32'h1, d)
      rd(`PWM_OFS_PERIOD, d, r);
      `CHK("period readback", pa, d)
      wr(`PWM_OFS_CTRL, c | 32'h1);
      rd(`PWM_OFS_CTRL, d, r);
      `CHK("flag on enable", 1'b1, d[`PWM_BIT_FLAG])
      period(n);
      wr(`PWM_OFS_PERIOD, pb);
      period(n);
      `CHK("buffered period", pa * div_of(k[3], k[2:0]), n)
      period(n);
      `CHK("new period", pb * div_of(k[3], k[2:0]), n)
      wr(`PWM_OFS_PERIOD, pa);
      wr(`PWM_OFS_CTRL, c | 32'h9);
      period(n);
      `CHK("load at once", pa * div_of(k[3], k[2:0]), n)
      wr(`PWM_OFS_WIDTH, 32'h0);
      repeat (pa * div_of(k[3], k[2:0])) @(posedge clk);
      `CHK("zero duty", output_polarity, pwm_pin)
      wr(`PWM_OFS_CTRL, c);
      $display("rate test %0d done", k);
    end
    give_verdict();
  end
endmodule : tb_pulse_width_modulator
